/* rtl/tcw_pkg.sv */
// constants, register map and modes of the 8-bit timer waveform block
package tcw_pkg;
  localparam int unsigned TCW_ADDR_W = 4;
  localparam logic [3:0] TCW_A_CTRL = 4'h0;
  localparam logic [3:0] TCW_A_CLKSEL = 4'h1;
  localparam logic [3:0] TCW_A_COUNT = 4'h2;
  localparam logic [3:0] TCW_A_LEVEL_A = 4'h3;
  localparam logic [3:0] TCW_A_LEVEL_B = 4'h4;
  localparam logic [3:0] TCW_A_FLAGS = 4'h5;
  localparam logic [3:0] TCW_A_FORCE = 4'h6;
  localparam logic [3:0] TCW_A_PORT = 4'h7;
  // ctrl fields
  localparam int unsigned TCW_F_MODE_LSB = 0;
  localparam int unsigned TCW_F_ACT_B_LSB = 4;
  localparam int unsigned TCW_F_ACT_A_LSB = 6;
  // flag and strobe positions
  localparam int unsigned TCW_F_WRAP = 0;
  localparam int unsigned TCW_F_MATCH_A = 1;
  localparam int unsigned TCW_F_MATCH_B = 2;
  localparam int unsigned TCW_F_FORCE_A = 0;
  localparam int unsigned TCW_F_FORCE_B = 1;
  // port register: bit0/1 port value a/b, bit2/3 direction a/b
  localparam int unsigned TCW_F_PVAL_A = 0;
  localparam int unsigned TCW_F_PVAL_B = 1;
  localparam int unsigned TCW_F_DIR_A = 2;
  localparam int unsigned TCW_F_DIR_B = 3;
  localparam logic [7:0] TCW_BOTTOM = 8'h00;
  localparam logic [7:0] TCW_MAX = 8'hFF;
  localparam logic [7:0] TCW_RST8 = 8'h00;
  localparam logic [2:0] TCW_WM_NORMAL = 3'h0;
  localparam logic [2:0] TCW_WM_CLEAR = 3'h2;
  localparam logic [2:0] TCW_WM_FAST_MAX = 3'h3;
  localparam logic [2:0] TCW_WM_FAST_LVL = 3'h7;
  localparam logic [1:0] TCW_ACT_NONE = 2'h0;
  localparam logic [1:0] TCW_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TCW_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TCW_ACT_SET = 2'h3;
  // prescaler choices by clock select 1..5
  localparam logic [2:0] TCW_CS_STOP = 3'h0;
  localparam logic [2:0] TCW_CS_DIV1 = 3'h1;
  localparam logic [2:0] TCW_CS_DIV8 = 3'h2;
  localparam logic [2:0] TCW_CS_DIV64 = 3'h3;
  localparam logic [2:0] TCW_CS_DIV256 = 3'h4;
  localparam logic [2:0] TCW_CS_DIV1024 = 3'h5;
  localparam int unsigned TCW_PRE_W = 10;
endpackage

/* rtl/tcw_timer8.sv */
// 8-bit timer with normal, clear-on-match and fast pwm waveform generation
//
// Local design decisions: the register addresses and strobed register access.
module tcw_timer8
  import tcw_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [TCW_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_ack_wrap,
  input wire logic i_ack_match_a,
  input wire logic i_ack_match_b,
  output logic o_wrap_flag,
  output logic o_match_flag_a,
  output logic o_match_flag_b,
  output logic o_pin_a_out,
  output logic o_pin_a_oe,
  output logic o_pin_b_out,
  output logic o_pin_b_oe
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [2:0] clock_select_r;
  logic [7:0] count_value_r;
  logic [7:0] level_a_r, level_b_r;
  logic [7:0] buf_a_r, buf_b_r;
  logic [3:0] port_r;
  logic wrap_flag_r, match_flag_a_r, match_flag_b_r;
  logic compare_output_a_r, compare_output_b_r;
  logic block_r;
  logic [7:0] rdata_r;
  logic [TCW_PRE_W-1:0] pre_r;

  logic [2:0] wave_mode_select;
  logic [1:0] output_action_a, output_action_b;
  logic fast_pwm, wave_mode_bit2, tick, at_top, top_to_bottom;
  logic match_a, match_b, cnt_wr, force_a, force_b;
  logic [7:0] top_val;

  assign wave_mode_select = ctrl_r[TCW_F_MODE_LSB +: 3];
  assign output_action_a = ctrl_r[TCW_F_ACT_A_LSB +: 2];
  assign output_action_b = ctrl_r[TCW_F_ACT_B_LSB +: 2];
  assign wave_mode_bit2 = wave_mode_select[2];
  assign fast_pwm = (wave_mode_select == TCW_WM_FAST_MAX) ||
                    (wave_mode_select == TCW_WM_FAST_LVL);
  assign cnt_wr = i_wr && (i_addr == TCW_A_COUNT);

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // one-cycle tick per prescaled period; select 0 gives none
  always_comb begin
    case (clock_select_r)
      TCW_CS_DIV1: tick = 1'b1;
      TCW_CS_DIV8: tick = (pre_r[2:0] == '1);
      TCW_CS_DIV64: tick = (pre_r[5:0] == '1);
      TCW_CS_DIV256: tick = (pre_r[7:0] == '1);
      TCW_CS_DIV1024: tick = (pre_r == '1);
      default: tick = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_comb begin
    if (wave_mode_select == TCW_WM_FAST_MAX || wave_mode_select == TCW_WM_NORMAL) begin
      top_val = TCW_MAX;
    end else begin
      top_val = level_a_r;
    end
  end
  assign at_top = (count_value_r == top_val);
  // compare with active levels, blocked on the tick after a count write
  assign match_a = (count_value_r == level_a_r) && !block_r;
  assign match_b = (count_value_r == level_b_r) && !block_r;
  assign top_to_bottom = tick && fast_pwm && at_top && !cnt_wr;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_value_r <= TCW_RST8;
    end else if (cnt_wr) begin
      count_value_r <= i_wdata;
    end else if (tick) begin
      case (wave_mode_select)
        TCW_WM_CLEAR: begin
          // immediate level; a low level lets the count run to wrap
          if (match_a) count_value_r <= TCW_BOTTOM;
          else count_value_r <= count_value_r + 8'h01;
        end
        TCW_WM_FAST_MAX, TCW_WM_FAST_LVL: begin
          if (at_top) count_value_r <= TCW_BOTTOM;
          else count_value_r <= count_value_r + 8'h01;
        end
        default: count_value_r <= count_value_r + 8'h01;
      endcase
    end
  end

  // a count write blocks matches until the next tick has passed
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      block_r <= 1'b0;
    end else if (cnt_wr) begin
      block_r <= 1'b1;
    end else if (tick) begin
      block_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // compare levels
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      buf_a_r <= TCW_RST8;
      buf_b_r <= TCW_RST8;
      level_a_r <= TCW_RST8;
      level_b_r <= TCW_RST8;
    end else begin
      if (i_wr && i_addr == TCW_A_LEVEL_A) buf_a_r <= i_wdata;
      if (i_wr && i_addr == TCW_A_LEVEL_B) buf_b_r <= i_wdata;
      if (!fast_pwm) begin
        // active level takes the written value so direct mode sees it at once
        if (i_wr && i_addr == TCW_A_LEVEL_A) level_a_r <= i_wdata;
        if (i_wr && i_addr == TCW_A_LEVEL_B) level_b_r <= i_wdata;
      end else if (top_to_bottom) begin
        level_a_r <= buf_a_r;
        level_b_r <= buf_b_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // flags: hardware set wins over the clear in the same cycle
  // ---------------------------------------------------------------
  logic set_wrap, set_ma, set_mb, clr_w;
  assign clr_w = i_wr && (i_addr == TCW_A_FLAGS);
  // wrap: normal/clear modes on max to zero, fast pwm on top to bottom
  assign set_wrap = tick && !cnt_wr && (fast_pwm ? at_top :
                    (count_value_r == TCW_MAX) && !(wave_mode_select == TCW_WM_CLEAR
                    && match_a));
  // set on the same tick in which the match is seen
  assign set_ma = tick && match_a;
  assign set_mb = tick && match_b;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wrap_flag_r <= 1'b0;
    end else if (set_wrap) begin
      wrap_flag_r <= 1'b1;
    end else if (i_ack_wrap || (clr_w && i_wdata[TCW_F_WRAP])) begin
      wrap_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      match_flag_a_r <= 1'b0;
    end else if (set_ma) begin
      match_flag_a_r <= 1'b1;
    end else if (i_ack_match_a || (clr_w && i_wdata[TCW_F_MATCH_A])) begin
      match_flag_a_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      match_flag_b_r <= 1'b0;
    end else if (set_mb) begin
      match_flag_b_r <= 1'b1;
    end else if (i_ack_match_b || (clr_w && i_wdata[TCW_F_MATCH_B])) begin
      match_flag_b_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // waveform output state
  // ---------------------------------------------------------------
  assign force_a = i_wr && (i_addr == TCW_A_FORCE) && i_wdata[TCW_F_FORCE_A] && !fast_pwm;
  assign force_b = i_wr && (i_addr == TCW_A_FORCE) && i_wdata[TCW_F_FORCE_B] && !fast_pwm;

  // next output state for one channel; the action field is read live
  function automatic logic wave_next(input logic cur, input logic [1:0] act,
                                     input logic fast, input logic hit,
                                     input logic wrapb, input logic tog_ok,
                                     input logic frc);
    logic r;
    r = cur;
    if (!fast) begin
      if (hit || frc) begin
        case (act)
          TCW_ACT_TOGGLE: r = ~cur;
          TCW_ACT_CLEAR: r = 1'b0;
          TCW_ACT_SET: r = 1'b1;
          default: r = cur;
        endcase
      end
    end else begin
      case (act)
        TCW_ACT_TOGGLE: r = (hit && tog_ok) ? ~cur : cur;
        // bottom edge wins, so a level of max holds the output constant
        TCW_ACT_CLEAR: r = wrapb ? 1'b1 : (hit ? 1'b0 : cur);
        TCW_ACT_SET: r = wrapb ? 1'b0 : (hit ? 1'b1 : cur);
        default: r = cur;
      endcase
    end
    return r;
  endfunction

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      compare_output_a_r <= 1'b0;
      compare_output_b_r <= 1'b0;
    end else begin
      compare_output_a_r <= wave_next(compare_output_a_r, output_action_a, fast_pwm,
                                      tick && match_a, top_to_bottom, wave_mode_bit2, force_a);
      compare_output_b_r <= wave_next(compare_output_b_r, output_action_b, fast_pwm,
                                      tick && match_b, top_to_bottom, 1'b0, force_b);
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_r <= TCW_RST8;
      clock_select_r <= TCW_CS_STOP;
      port_r <= '0;
    end else if (i_wr) begin
      case (i_addr)
        TCW_A_CTRL: ctrl_r <= i_wdata;
        TCW_A_CLKSEL: clock_select_r <= i_wdata[2:0];
        TCW_A_PORT: port_r <= i_wdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_r <= TCW_RST8;
    end else if (i_rd) begin
      case (i_addr)
        TCW_A_CTRL: rdata_r <= ctrl_r;
        TCW_A_CLKSEL: rdata_r <= {5'h00, clock_select_r};
        TCW_A_COUNT: rdata_r <= count_value_r;
        TCW_A_LEVEL_A: rdata_r <= buf_a_r;
        TCW_A_LEVEL_B: rdata_r <= buf_b_r;
        TCW_A_FLAGS: rdata_r <= {5'h00, match_flag_b_r, match_flag_a_r, wrap_flag_r};
        TCW_A_PORT: rdata_r <= {2'h0, compare_output_b_r, compare_output_a_r, port_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // pin takeover
  // ---------------------------------------------------------------
  always_comb begin
    o_pin_a_out = (output_action_a != TCW_ACT_NONE) ? compare_output_a_r
                                                    : port_r[TCW_F_PVAL_A];
    o_pin_b_out = (output_action_b != TCW_ACT_NONE) ? compare_output_b_r
                                                    : port_r[TCW_F_PVAL_B];
  end
  assign o_pin_a_oe = port_r[TCW_F_DIR_A];
  assign o_pin_b_oe = port_r[TCW_F_DIR_B];
  assign o_rdata = rdata_r;
  assign o_wrap_flag = wrap_flag_r;
  assign o_match_flag_a = match_flag_a_r;
  assign o_match_flag_b = match_flag_b_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_reset_out;
    @(posedge i_ref_clk) $rose(i_resetn) |-> !compare_output_a_r && !compare_output_b_r;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("output state not cleared");

  property p_takeover;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (output_action_a != TCW_ACT_NONE) |-> o_pin_a_out == compare_output_a_r;
  endproperty
  a_takeover: assert property (p_takeover) else $error("pin a not taken over");

  property p_oe_dir;
    @(posedge i_ref_clk) disable iff (!i_resetn) o_pin_b_oe == port_r[TCW_F_DIR_B];
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("pin b enable wrong");

  property p_hold_none;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (output_action_a == TCW_ACT_NONE) |=> $stable(compare_output_a_r);
  endproperty
  a_hold_none: assert property (p_hold_none) else $error("output a moved");

  property p_normal_wrap;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (wave_mode_select == TCW_WM_NORMAL && tick && !cnt_wr && count_value_r == TCW_MAX)
      |=> count_value_r == TCW_BOTTOM && wrap_flag_r;
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap wrong");

  property p_ctc_clear;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (wave_mode_select == TCW_WM_CLEAR && tick && !cnt_wr && match_a)
      |=> count_value_r == TCW_BOTTOM && match_flag_a_r;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("clear on match wrong");

  property p_cnt_wr;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      cnt_wr |=> count_value_r == $past(i_wdata) && block_r;
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("count write lost");

  property p_blocked;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (block_r && !cnt_wr && !set_wrap && !i_ack_match_a && !clr_w) |=> $stable(match_flag_a_r);
  endproperty
  a_blocked: assert property (p_blocked) else $error("match during block");

  property p_pwm_bottom;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (top_to_bottom && output_action_a == TCW_ACT_CLEAR) |=> compare_output_a_r
      && count_value_r == TCW_BOTTOM && level_a_r == $past(buf_a_r);
  endproperty
  a_pwm_bottom: assert property (p_pwm_bottom) else $error("pwm bottom wrong");

  c_ctc: cover property (@(posedge i_ref_clk) wave_mode_select == TCW_WM_CLEAR && set_ma);
  c_pwm: cover property (@(posedge i_ref_clk) top_to_bottom);
  c_force: cover property (@(posedge i_ref_clk) force_a);
endmodule // tcw_timer8

/* sim/tcw_pin_model.sv */
// port pin model: the wire the block drives through its compare outputs
module tcw_pin_model (
  input wire logic i_ref_clk,
  input wire logic i_oe,
  input wire logic i_out,
  output logic o_level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_r = 1'b0;
  // no pull on this wire: a released pin floats to the inverse of its last driven value
  always_ff @(posedge i_ref_clk) begin
    if (i_oe) begin
      last_r <= ~i_out;
    end
  end
  assign o_level = i_oe ? i_out : last_r;
endmodule // tcw_pin_model

/* sim/tcw_timer8_tb.sv */
// self-checking bench for the 8-bit timer waveform block
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module tcw_timer8_tb
  import tcw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CEIL = 30000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [TCW_ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ack_w = 1'b0;
  logic ack_a = 1'b0;
  logic ack_b = 1'b0;
  logic [7:0] rdata;
  logic wrap_f, match_a, match_b, pa_out, pa_oe, pb_out, pb_oe, pin_a, pin_b;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int hi, lo, n;

  always #2.5 clk = ~clk;

  tcw_timer8 uut (
    .i_ref_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_ack_wrap(ack_w), .i_ack_match_a(ack_a),
    .i_ack_match_b(ack_b), .o_wrap_flag(wrap_f), .o_match_flag_a(match_a),
    .o_match_flag_b(match_b), .o_pin_a_out(pa_out), .o_pin_a_oe(pa_oe),
    .o_pin_b_out(pb_out), .o_pin_b_oe(pb_oe)
  );
  tcw_pin_model pin_a_m (.i_ref_clk(clk), .i_oe(pa_oe), .i_out(pa_out), .o_level(pin_a));
  tcw_pin_model pin_b_m (.i_ref_clk(clk), .i_oe(pb_oe), .i_out(pb_out), .o_level(pin_b));

  // ----------------------------------------
  // bus and measuring helpers
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      num_errors++;
      close_out();
    end
  end

  function automatic logic [7:0] ctl(input logic [2:0] m, input logic [1:0] a,
                                     input logic [1:0] b);
    return {a, b, 1'b0, m};
  endfunction

  function automatic logic sig(input int s);
    case (s)
      0: return pin_a;
      1: return pin_b;
      2: return wrap_f;
      3: return match_a;
      default: return match_b;
    endcase
  endfunction

  task automatic wr_reg(input logic [TCW_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rd_chk(input logic [TCW_ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask

  // counts cycles until the watched signal reaches v
  task automatic wait_lvl(input int s, input logic v, output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (sig(s) !== v && c < 2500);
    if (c >= 2500) `CHK(c, 0)
  endtask

  task automatic pulse_hl(input int s, output int h, output int l);
    wait_lvl(s, 1'b0, n);
    wait_lvl(s, 1'b1, n);
    wait_lvl(s, 1'b0, h);
    wait_lvl(s, 1'b1, l);
  endtask

  // flags are sticky: service until seen clear, then time two set events
  task automatic flag_period(input int s, output int p);
    int t0;
    t0 = 0;
    p = 0;
    repeat (2) begin
      do begin
        @(posedge clk);
        ack_w <= (s == 2);
        ack_a <= (s == 3);
        ack_b <= (s == 4);
        @(posedge clk);
        ack_w <= 1'b0;
        ack_a <= 1'b0;
        ack_b <= 1'b0;
        @(negedge clk);
      end while (sig(s) !== 1'b0);
      wait_lvl(s, 1'b1, n);
      p = cyc - t0;
      t0 = cyc;
    end
  endtask

  task automatic stays(input int s, input logic v);
    int k;
    k = 0;
    repeat (300) begin
      @(negedge clk);
      if (sig(s) !== v) k++;
    end
    `CHK(k, 0)
  endtask

  task automatic arm(input logic [2:0] m, input logic [1:0] a, input logic [1:0] b,
                     input logic [7:0] la, input logic [7:0] lb);
    wr_reg(TCW_A_CLKSEL, 8'h00);
    wr_reg(TCW_A_CTRL, 8'h00);
    wr_reg(TCW_A_LEVEL_A, la);
    wr_reg(TCW_A_LEVEL_B, lb);
    wr_reg(TCW_A_CTRL, ctl(m, a, b));
    wr_reg(TCW_A_PORT, 8'h0C);
    wr_reg(TCW_A_COUNT, 8'h00);
    wr_reg(TCW_A_FLAGS, 8'h07);
    wr_reg(TCW_A_CLKSEL, {5'h00, TCW_CS_DIV1});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    @(negedge clk);
    `CHK(pa_oe, 1'b0)
    rd_chk(TCW_A_CTRL, 8'h00);
    rd_chk(TCW_A_PORT, 8'h00);
    wr_reg(4'h9, 8'h5A);
    rd_chk(4'h9, 8'h00);
  endtask

  task automatic t_force();
    wr_reg(TCW_A_PORT, 8'h0D);
    `CHK(pa_out, 1'b1)
    `CHK(pa_oe, 1'b1)
    wr_reg(TCW_A_CTRL, ctl(TCW_WM_NORMAL, TCW_ACT_SET, TCW_ACT_NONE));
    `CHK(pa_out, 1'b0)
    wr_reg(TCW_A_FORCE, 8'h01);
    `CHK(pa_out, 1'b1)
    `CHK(match_a, 1'b0)
    rd_chk(TCW_A_COUNT, 8'h00);
    wr_reg(TCW_A_CTRL, 8'h00);
    wr_reg(TCW_A_FORCE, 8'h01);
    wr_reg(TCW_A_CTRL, ctl(TCW_WM_NORMAL, TCW_ACT_CLEAR, TCW_ACT_NONE));
    `CHK(pa_out, 1'b1)
    wr_reg(TCW_A_FORCE, 8'h01);
    `CHK(pa_out, 1'b0)
    wr_reg(TCW_A_CTRL, ctl(TCW_WM_NORMAL, TCW_ACT_TOGGLE, TCW_ACT_NONE));
    wr_reg(TCW_A_FORCE, 8'h01);
    `CHK(pa_out, 1'b1)
    wr_reg(TCW_A_PORT, 8'h01);
    `CHK(pa_oe, 1'b0)
    `CHK(pin_a, 1'b0)
  endtask

  task automatic t_normal();
    arm(TCW_WM_NORMAL, TCW_ACT_TOGGLE, TCW_ACT_NONE, 8'h10, 8'h20);
    flag_period(2, n);
    `CHK(n, 256)
    pulse_hl(0, hi, lo);
    `CHK(hi, 256)
  endtask

  task automatic t_ctc();
    arm(TCW_WM_CLEAR, TCW_ACT_TOGGLE, TCW_ACT_NONE, 8'h09, 8'h00);
    flag_period(3, n);
    `CHK(n, 10)
    pulse_hl(0, hi, lo);
    `CHK(hi, 10)
    `CHK(lo, 10)
    wr_reg(TCW_A_CLKSEL, 8'h00);
    wr_reg(TCW_A_COUNT, 8'h20);
    repeat (10) @(negedge clk);
    rd_chk(TCW_A_COUNT, 8'h20);
    wr_reg(TCW_A_LEVEL_A, 8'h05);
    wr_reg(TCW_A_FLAGS, 8'h07);
    wr_reg(TCW_A_CLKSEL, {5'h00, TCW_CS_DIV1});
    wait_lvl(3, 1'b1, n);
    `CHK(n > 200, 1'b1)
    `CHK(wrap_f, 1'b1)
    wr_reg(TCW_A_CLKSEL, 8'h00);
    wr_reg(TCW_A_COUNT, 8'h05);
    wr_reg(TCW_A_FLAGS, 8'h07);
    wr_reg(TCW_A_CLKSEL, {5'h00, TCW_CS_DIV1});
    repeat (20) @(negedge clk);
    `CHK(match_a, 1'b0)
  endtask

  task automatic t_fast();
    arm(TCW_WM_FAST_MAX, TCW_ACT_CLEAR, TCW_ACT_CLEAR, 8'h3F, 8'h10);
    pulse_hl(0, hi, lo);
    `CHK(hi, 8'h40)
    `CHK(hi + lo, 256)
    pulse_hl(1, hi, lo);
    `CHK(hi, 8'h11)
    flag_period(2, n);
    `CHK(n, 256)
    wr_reg(TCW_A_CTRL, ctl(TCW_WM_FAST_MAX, TCW_ACT_SET, TCW_ACT_TOGGLE));
    pulse_hl(0, hi, lo);
    `CHK(lo, 8'h40)
    lo = pin_b;
    wr_reg(TCW_A_FORCE, 8'h03);
    stays(1, lo[0]);
    wr_reg(TCW_A_CTRL, ctl(TCW_WM_FAST_MAX, TCW_ACT_CLEAR, TCW_ACT_NONE));
    wr_reg(TCW_A_LEVEL_A, 8'hFF);
    repeat (300) @(negedge clk);
    stays(0, 1'b1);
    wr_reg(TCW_A_LEVEL_A, 8'h00);
    pulse_hl(0, hi, lo);
    pulse_hl(0, hi, lo);
    `CHK(hi, 1)
    `CHK(lo, 255)
  endtask

  task automatic t_lvl();
    arm(TCW_WM_FAST_LVL, TCW_ACT_TOGGLE, TCW_ACT_TOGGLE, 8'h09, 8'h03);
    pulse_hl(0, hi, lo);
    `CHK(hi, 10)
    `CHK(lo, 10)
    flag_period(2, n);
    `CHK(n, 10)
    stays(1, pin_b);
    flag_period(2, n);
    repeat (4) @(negedge clk);
    wr_reg(TCW_A_LEVEL_A, 8'h01);
    wr_reg(TCW_A_FLAGS, 8'h07);
    wait_lvl(2, 1'b1, n);
    `CHK(n < 20, 1'b1)
    pulse_hl(0, hi, lo);
    `CHK(hi, 2)
  endtask

  // level 1 in clear-on-match gives a match every second tick
  task automatic t_pre();
    arm(TCW_WM_CLEAR, TCW_ACT_NONE, TCW_ACT_NONE, 8'h01, 8'h00);
    wr_reg(TCW_A_CLKSEL, {5'h00, TCW_CS_DIV8});
    flag_period(3, n);
    `CHK(n, 16)
    flag_period(4, n);
    `CHK(n, 16)
    wr_reg(TCW_A_CLKSEL, {5'h00, TCW_CS_DIV64});
    flag_period(3, n);
    `CHK(n, 128)
    wr_reg(TCW_A_CLKSEL, {5'h00, TCW_CS_DIV256});
    flag_period(3, n);
    `CHK(n, 512)
    wr_reg(TCW_A_CLKSEL, {5'h00, TCW_CS_DIV1024});
    flag_period(3, n);
    `CHK(n, 2048)
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_force();
    t_normal();
    t_ctc();
    t_fast();
    t_lvl();
    t_pre();
    close_out();
  end
endmodule // tcw_timer8_tb
